//--- src/ncrb_node_config.sv
// node configuration register bank with routing lookup
// Functional notes
// [RULE1] access only by configuration read and write
// [RULE2] identity: boot pins, switch revision, version
// [RULE3] topology: link, switch, device processor counts
// [RULE4] guard bit 31 refuses control writes
// [RULE5] guard bit 8 blocks pll writes
// [RULE6] guard bit 0 selects header size
// [RULE7] route id 16 bits, upper read-only
// [RULE8] pll write resets tile unless suppressed
// [RULE9] pll bit 31 skips the reset
// [RULE10] pll bit 30 skips relock wait
// [RULE11] pll bit 29 bypasses the pll
// [RULE12] pll bit 28 forces jtag boot
// [RULE13] output divider in bits 25:23
// [RULE14] feedback multiplier in bits 20:8
// [RULE15] input divider in bits 6:0
// [RULE16] switch clock ratio, resets to zero
// [RULE17] reference clock ratio, resets to three
// [RULE18] jtag identity word read-only
// [RULE19] user code: otp code and id code
// [RULE20] route by top mismatching identifier bit
// [RULE21] low table holds dimensions 7..0
// [RULE22] high table holds dimensions 15..8
// [RULE23] read-only and reserved writes ignored, read zero
// [RULE24] matching destination is delivered locally
module ncrb_node_config (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] boot_select_pins,
	input wire logic [13:0] otp_user_code,
	input wire logic [17:0] metal_id_code,
	input wire ncrb_pkg::ncrb_cfg_req_t cfg_req,
	output ncrb_pkg::ncrb_cfg_rsp_t cfg_rsp,
	input wire ncrb_pkg::ncrb_route_req_t route_req,
	output ncrb_pkg::ncrb_route_rsp_t route_rsp,
	output logic one_byte_hdr_q,
	output logic [15:0] node_id_q,
	output logic [2:0] pll_out_div_q,
	output logic [12:0] pll_fb_mult_q,
	output logic [6:0] pll_in_div_q,
	output logic pll_bypass_q,
	output logic boot_from_jtag_q,
	output logic pll_no_relock_q,
	output logic pll_apply_q,
	output logic tile_reset_q,
	output logic [15:0] switch_div_q,
	output logic [15:0] ref_div_q
);

	typedef enum logic [1:0] {
		CAP_SYNC1,
		CAP_SYNC2,
		CAP_SYNC3,
		CAP_DONE
	} ncrb_cap_state_t;

	ncrb_cap_state_t cap_state_q;
	ncrb_cap_state_t cap_state_d;
	logic [7:0] boot_meta_q;
	logic [7:0] boot_sync_q;
	logic [7:0] boot_strap_q;

	logic [31:0] guard_q;
	logic [31:0] pll_q;
	logic [31:0] dirs_low_q;
	logic [31:0] dirs_high_q;
	logic [1:0] spare_q;

	// request decode
	logic rd_req;
	logic wr_req;
	logic hit_identity;
	logic hit_topology;
	logic hit_guard;
	logic hit_node_id;
	logic hit_pll;
	logic hit_switch_div;
	logic hit_ref_div;
	logic hit_jtag_id;
	logic hit_user_code;
	logic hit_dirs_low;
	logic hit_dirs_high;
	logic hit_spare;
	logic hit_writable;
	logic hit_any;
	logic switch_locked;
	logic pll_locked;
	logic wr_ok;
	logic wr_guard;
	logic wr_node_id;
	logic wr_pll;
	logic wr_switch_div;
	logic wr_ref_div;
	logic wr_dirs_low;
	logic wr_dirs_high;
	logic wr_spare;
	logic [31:0] rd_value;
	logic [31:0] identity_word;
	logic [31:0] topology_word;
	logic [31:0] user_code_word;
	logic [31:0] pll_read;
	logic rsp_ack;

	// masked merge of write data into a register
	function automatic logic [31:0] ncrb_merge(
		input logic [31:0] old_value,
		input logic [31:0] new_value,
		input logic [31:0] mask
	);
		return (old_value & ~mask) | (new_value & mask);
	endfunction : ncrb_merge

	// boot pins cross into the clock domain
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			boot_meta_q <= 8'h00;
			boot_sync_q <= 8'h00;
		end
		else
		begin
			boot_meta_q <= boot_select_pins;
			boot_sync_q <= boot_meta_q;
		end
	end

	// strap capture sequence after reset release
	always_comb
	begin
		cap_state_d = cap_state_q;
		case (cap_state_q)
			CAP_SYNC1: cap_state_d = CAP_SYNC2;
			CAP_SYNC2: cap_state_d = CAP_SYNC3;
			CAP_SYNC3: cap_state_d = CAP_DONE;
			CAP_DONE: cap_state_d = CAP_DONE;
			default: cap_state_d = CAP_SYNC1;
		endcase
	end

	// [RULE2] pin levels held once after power-on
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cap_state_q <= CAP_SYNC1;
			boot_strap_q <= 8'h00;
		end
		else
		begin
			cap_state_q <= cap_state_d;
			if (cap_state_q == CAP_SYNC3) // both sync stages hold pins
				boot_strap_q <= boot_sync_q;
		end
	end

	// [RULE1] only configuration transactions reach the bank
	assign rd_req = cfg_req.valid & ~cfg_req.write;
	assign wr_req = cfg_req.valid & cfg_req.write;

	// address decode
	assign hit_identity = (cfg_req.addr == ncrb_pkg::OFS_NODE_IDENTITY);
	assign hit_topology = (cfg_req.addr == ncrb_pkg::OFS_SWITCH_TOPOLOGY);
	assign hit_guard = (cfg_req.addr == ncrb_pkg::OFS_ACCESS_GUARD);
	assign hit_node_id = (cfg_req.addr == ncrb_pkg::OFS_NODE_ROUTE_ID);
	assign hit_pll = (cfg_req.addr == ncrb_pkg::OFS_PLL_SETUP);
	assign hit_switch_div = (cfg_req.addr == ncrb_pkg::OFS_SWITCH_CLK_RATIO);
	assign hit_ref_div = (cfg_req.addr == ncrb_pkg::OFS_REF_CLK_RATIO);
	assign hit_jtag_id = (cfg_req.addr == ncrb_pkg::OFS_JTAG_ID_WORD);
	assign hit_user_code = (cfg_req.addr == ncrb_pkg::OFS_USER_CODE_WORD);
	assign hit_dirs_low = (cfg_req.addr == ncrb_pkg::OFS_ROUTE_DIRS_LOW);
	assign hit_dirs_high = (cfg_req.addr == ncrb_pkg::OFS_ROUTE_DIRS_HIGH);
	assign hit_spare = (cfg_req.addr == ncrb_pkg::OFS_SPARE_BITS);
	assign hit_writable = hit_guard | hit_node_id | hit_pll | hit_switch_div
		| hit_ref_div | hit_dirs_low | hit_dirs_high | hit_spare;
	assign hit_any = hit_writable | hit_identity | hit_topology
		| hit_jtag_id | hit_user_code;

	// [RULE4] switch lock refuses every control write
	assign switch_locked = guard_q[ncrb_pkg::GUARD_SWITCH_LOCK_BIT];
	// [RULE5] pll lock blocks only the pll register
	assign pll_locked = guard_q[ncrb_pkg::GUARD_PLL_LOCK_BIT];
	assign wr_ok = wr_req & ~switch_locked;

	// per-register write strobes
	assign wr_guard = wr_ok & hit_guard;
	assign wr_node_id = wr_ok & hit_node_id;
	assign wr_pll = wr_ok & hit_pll & ~pll_locked;
	assign wr_switch_div = wr_ok & hit_switch_div;
	assign wr_ref_div = wr_ok & hit_ref_div;
	assign wr_dirs_low = wr_ok & hit_dirs_low;
	assign wr_dirs_high = wr_ok & hit_dirs_high;
	assign wr_spare = wr_ok & hit_spare;

	// [RULE4] [RULE6] guard register, masked write
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			guard_q <= ncrb_pkg::GUARD_RESET;
		else if (wr_guard)
			guard_q <= ncrb_merge(guard_q, cfg_req.wdata,
				ncrb_pkg::GUARD_WRITE_MASK);
	end

	// [RULE6] header size select to the switch
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			one_byte_hdr_q <= 1'b0;
		else if (wr_guard)
			one_byte_hdr_q <= cfg_req.wdata[ncrb_pkg::GUARD_HDR_ONE_BYTE_BIT];
	end

	// [RULE7] node routing identifier
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			node_id_q <= ncrb_pkg::NODE_ID_RESET;
		else if (wr_node_id)
			node_id_q <= cfg_req.wdata[15:0];
	end

	// [RULE13] [RULE14] [RULE15] pll fields, reserved masked out
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pll_q <= ncrb_pkg::PLL_SETUP_RESET;
		else if (wr_pll)
			pll_q <= ncrb_merge(pll_q, cfg_req.wdata,
				ncrb_pkg::PLL_WRITE_MASK);
	end

	// pll field outputs mirror the stored word
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pll_out_div_q <= ncrb_pkg::PLL_SETUP_RESET[25:23];
			pll_fb_mult_q <= ncrb_pkg::PLL_SETUP_RESET[20:8];
			pll_in_div_q <= ncrb_pkg::PLL_SETUP_RESET[6:0];
			pll_bypass_q <= 1'b0;
			boot_from_jtag_q <= 1'b0;
			pll_no_relock_q <= 1'b0;
		end
		else if (wr_pll)
		begin
			pll_out_div_q <= cfg_req.wdata[25:23];
			pll_fb_mult_q <= cfg_req.wdata[20:8];
			pll_in_div_q <= cfg_req.wdata[6:0];
			// [RULE11] bypass routes clock around pll
			pll_bypass_q <= cfg_req.wdata[ncrb_pkg::PLL_BYPASS_BIT];
			// [RULE12] force boot over jtag
			boot_from_jtag_q <= cfg_req.wdata[ncrb_pkg::PLL_JTAG_BOOT_BIT];
			// [RULE10] relock wait skipped when set
			pll_no_relock_q <= cfg_req.wdata[ncrb_pkg::PLL_NO_RELOCK_BIT];
		end
	end

	// [RULE8] [RULE9] one-cycle reset and apply pulses
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			pll_apply_q <= 1'b0;
			tile_reset_q <= 1'b0;
		end
		else
		begin
			pll_apply_q <= wr_pll;
			tile_reset_q <= wr_pll & ~cfg_req.wdata[ncrb_pkg::PLL_NO_RESET_BIT];
		end
	end

	// [RULE16] switch clock ratio
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			switch_div_q <= ncrb_pkg::SWITCH_DIV_RESET;
		else if (wr_switch_div)
			switch_div_q <= cfg_req.wdata[15:0];
	end

	// [RULE17] reference clock ratio
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ref_div_q <= ncrb_pkg::REF_DIV_RESET;
		else if (wr_ref_div)
			ref_div_q <= cfg_req.wdata[15:0];
	end

	// [RULE21] [RULE22] direction tables
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			dirs_low_q <= ncrb_pkg::DIRS_RESET;
			dirs_high_q <= ncrb_pkg::DIRS_RESET;
		end
		else
		begin
			if (wr_dirs_low)
				dirs_low_q <= cfg_req.wdata;
			if (wr_dirs_high)
				dirs_high_q <= cfg_req.wdata;
		end
	end

	// spare bits 1:0, upper bits read zero
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			spare_q <= ncrb_pkg::SPARE_RESET;
		else if (wr_spare)
			spare_q <= cfg_req.wdata[1:0];
	end

	// [RULE2] identity word, reserved top byte zero
	assign identity_word = {8'h00, boot_strap_q,
		ncrb_pkg::SWITCH_REVISION, ncrb_pkg::SWITCH_VERSION};
	// [RULE3] topology word, reserved top byte zero
	assign topology_word = {8'h00, ncrb_pkg::SERIAL_LINK_COUNT,
		ncrb_pkg::SWITCH_PROC_COUNT, ncrb_pkg::DEVICE_PROC_COUNT};
	// [RULE19] user code from otp and metal id
	assign user_code_word = {otp_user_code, metal_id_code};
	// [RULE23] reserved pll bits read zero
	assign pll_read = pll_q & ncrb_pkg::PLL_WRITE_MASK;

	// [RULE18] [RULE23] read selection, unmapped reads zero
	assign rd_value =
		hit_identity ? identity_word :
		hit_topology ? topology_word :
		hit_guard ? (guard_q & ncrb_pkg::GUARD_WRITE_MASK) :
		hit_node_id ? {16'h0000, node_id_q} :
		hit_pll ? pll_read :
		hit_switch_div ? {16'h0000, switch_div_q} :
		hit_ref_div ? {16'h0000, ref_div_q} :
		hit_jtag_id ? ncrb_pkg::JTAG_ID_VALUE :
		hit_user_code ? user_code_word :
		hit_dirs_low ? dirs_low_q :
		hit_dirs_high ? dirs_high_q :
		hit_spare ? {30'h0, spare_q} :
		32'h0000_0000;

	// ack: mapped read, or write that took effect
	assign rsp_ack = rd_req ? hit_any
		: (wr_guard | wr_node_id | wr_pll | wr_switch_div | wr_ref_div
		| wr_dirs_low | wr_dirs_high | wr_spare);

	// response one cycle after each request
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			cfg_rsp <= '0;
		else
		begin
			cfg_rsp.valid <= cfg_req.valid;
			cfg_rsp.ack <= cfg_req.valid & rsp_ack;
			cfg_rsp.rdata <= rd_req ? rd_value : 32'h0000_0000;
		end
	end

	// [RULE20] [RULE24] routing lookup on live tables
	ncrb_router u_router (
		.clock(clock),
		.rst(rst),
		.req(route_req),
		.node_id(node_id_q),
		.dirs_low(dirs_low_q),
		.dirs_high(dirs_high_q),
		.rsp(route_rsp)
	);

endmodule : ncrb_node_config

//--- src/ncrb_pkg.sv
// package of offsets, fields, reset values and carrier types
package ncrb_pkg;

	// register indices on the configuration port
	localparam logic [7:0] OFS_NODE_IDENTITY = 8'h00;
	localparam logic [7:0] OFS_SWITCH_TOPOLOGY = 8'h01;
	localparam logic [7:0] OFS_ACCESS_GUARD = 8'h04;
	localparam logic [7:0] OFS_NODE_ROUTE_ID = 8'h05;
	localparam logic [7:0] OFS_PLL_SETUP = 8'h06;
	localparam logic [7:0] OFS_SWITCH_CLK_RATIO = 8'h07;
	localparam logic [7:0] OFS_REF_CLK_RATIO = 8'h08;
	localparam logic [7:0] OFS_JTAG_ID_WORD = 8'h09;
	localparam logic [7:0] OFS_USER_CODE_WORD = 8'h0A;
	localparam logic [7:0] OFS_ROUTE_DIRS_LOW = 8'h0C;
	localparam logic [7:0] OFS_ROUTE_DIRS_HIGH = 8'h0D;
	localparam logic [7:0] OFS_SPARE_BITS = 8'h10;

	// access guard fields
	localparam int GUARD_SWITCH_LOCK_BIT = 31;
	localparam int GUARD_PLL_LOCK_BIT = 8;
	localparam int GUARD_HDR_ONE_BYTE_BIT = 0;

	// pll setup fields
	localparam int PLL_NO_RESET_BIT = 31;
	localparam int PLL_NO_RELOCK_BIT = 30;
	localparam int PLL_BYPASS_BIT = 29;
	localparam int PLL_JTAG_BOOT_BIT = 28;
	localparam logic [31:0] PLL_WRITE_MASK = 32'hF39F_FF7F;
	localparam logic [31:0] PLL_SETUP_RESET = 32'h0000_0000;

	// writable masks of the simpler registers
	localparam logic [31:0] GUARD_WRITE_MASK = 32'h8000_0101;
	localparam logic [31:0] LOW16_MASK = 32'h0000_FFFF;
	localparam logic [31:0] SPARE_WRITE_MASK = 32'h0000_0003;

	// reset values
	localparam logic [31:0] GUARD_RESET = 32'h0000_0000;
	localparam logic [15:0] NODE_ID_RESET = 16'h0000;
	localparam logic [15:0] SWITCH_DIV_RESET = 16'h0000;
	localparam logic [15:0] REF_DIV_RESET = 16'h0003;
	localparam logic [31:0] DIRS_RESET = 32'h0000_0000;
	localparam logic [1:0] SPARE_RESET = 2'h0;

	// identity values, arbitrary neutral codes
	localparam logic [7:0] SWITCH_REVISION = 8'h01;
	localparam logic [7:0] SWITCH_VERSION = 8'h02;
	localparam logic [31:0] JTAG_ID_VALUE = 32'h1000_0001;
	// topology counts, plain defaults
	localparam logic [7:0] SERIAL_LINK_COUNT = 8'h08;
	localparam logic [7:0] SWITCH_PROC_COUNT = 8'h02;
	localparam logic [7:0] DEVICE_PROC_COUNT = 8'h02;

	// configuration transaction carriers
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} ncrb_cfg_req_t;

	typedef struct packed {
		logic valid;
		logic ack;
		logic [31:0] rdata;
	} ncrb_cfg_rsp_t;

	// routing lookup carriers
	typedef struct packed {
		logic valid;
		logic [15:0] dest;
	} ncrb_route_req_t;

	typedef struct packed {
		logic valid;
		logic local_hit;
		logic [3:0] dim;
		logic [3:0] dir;
	} ncrb_route_rsp_t;

endpackage : ncrb_pkg

//--- src/ncrb_router.sv
// routing lookup by most significant mismatching identifier bit
module ncrb_router (
	input wire logic clock,
	input wire logic rst,
	input wire ncrb_pkg::ncrb_route_req_t req,
	input wire logic [15:0] node_id,
	input wire logic [31:0] dirs_low,
	input wire logic [31:0] dirs_high,
	output ncrb_pkg::ncrb_route_rsp_t rsp
);

	// index of highest set bit of the mismatch vector
	function automatic logic [3:0] ncrb_msb_index(input logic [15:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 16; i++)
		begin
			if (v[i])
				idx = 4'(i);
		end
		return idx;
	endfunction : ncrb_msb_index

	logic [15:0] mismatch;
	logic [3:0] dim;
	logic [63:0] table_all;
	logic [3:0] dir_sel;
	logic is_local;

	// [RULE20] mismatch dimension selects nibble
	assign mismatch = req.dest ^ node_id;
	assign dim = ncrb_msb_index(mismatch);
	// [RULE21] [RULE22] tables joined, dimension k at 4k
	assign table_all = {dirs_high, dirs_low};
	assign dir_sel = table_all[{dim, 2'b00} +: 4];
	// [RULE24] full match is delivered locally
	assign is_local = (mismatch == 16'h0000);

	// registered answer one cycle after the request
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			rsp <= '0;
		else
		begin
			rsp.valid <= req.valid;
			rsp.local_hit <= req.valid & is_local;
			rsp.dim <= is_local ? 4'h0 : dim;
			rsp.dir <= is_local ? 4'h0 : dir_sel;
		end
	end

endmodule : ncrb_router

//--- tb/ncrb_asserts.sv
// checker for the node configuration register bank
module ncrb_asserts (
	input wire logic clock,
	input wire logic rst,
	input wire ncrb_pkg::ncrb_cfg_req_t cfg_req,
	input wire ncrb_pkg::ncrb_cfg_rsp_t cfg_rsp,
	input wire ncrb_pkg::ncrb_route_req_t route_req,
	input wire ncrb_pkg::ncrb_route_rsp_t route_rsp,
	input wire logic [15:0] node_id_q,
	input wire logic [12:0] pll_fb_mult_q,
	input wire logic pll_bypass_q,
	input wire logic boot_from_jtag_q,
	input wire logic pll_no_relock_q,
	input wire logic pll_apply_q,
	input wire logic tile_reset_q,
	input wire logic [15:0] ref_div_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// decoded write strobes and local route match
	wire logic any_wr = cfg_req.valid && cfg_req.write;
	wire logic pll_wr = any_wr && cfg_req.addr == ncrb_pkg::OFS_PLL_SETUP;
	wire logic id_wr = any_wr && cfg_req.addr == ncrb_pkg::OFS_NODE_IDENTITY;
	wire logic hit = route_req.valid && route_req.dest == node_id_q;

	chk_rsp_next_cycle: assert property (cfg_req.valid |=> cfg_rsp.valid)
		else $error("config response missing");
	chk_rsp_no_spurious: assert property (!cfg_req.valid |=> !cfg_rsp.valid)
		else $error("spurious config response");
	chk_ro_write_nack: assert property (id_wr |=> !cfg_rsp.ack)
		else $error("identity write acknowledged");
	chk_reset_needs_write: assert property (tile_reset_q |-> pll_apply_q)
		else $error("tile reset without pll write");
	chk_apply_source: assert property (pll_apply_q |-> $past(pll_wr))
		else $error("pll apply without pll write");
	chk_skip_reset: assert property (pll_apply_q |->
		tile_reset_q == !$past(cfg_req.wdata[31]))
		else $error("tile reset against no-reset bit");
	chk_relock_bit: assert property (pll_apply_q |->
		pll_no_relock_q == $past(cfg_req.wdata[30]))
		else $error("relock bit wrong");
	chk_bypass_bit: assert property (pll_apply_q |->
		pll_bypass_q == $past(cfg_req.wdata[29]))
		else $error("bypass bit wrong");
	chk_jtag_boot: assert property (pll_apply_q |->
		boot_from_jtag_q == $past(cfg_req.wdata[28]))
		else $error("jtag boot bit wrong");
	chk_fb_mult: assert property (pll_apply_q |->
		pll_fb_mult_q == $past(cfg_req.wdata[20:8]))
		else $error("feedback multiplier wrong");
	chk_local_hit: assert property (hit |=> route_rsp.valid &&
		route_rsp.local_hit)
		else $error("matching destination not local");
	chk_ref_div_hold: assert property (!any_wr |=> $stable(ref_div_q))
		else $error("ref divider changed without write");

	// main scenarios reached
	cov_pll_no_reset: cover property (pll_apply_q && !tile_reset_q);
	cov_refused: cover property (cfg_rsp.valid && !cfg_rsp.ack);
	cov_local: cover property (route_rsp.valid && route_rsp.local_hit);
endmodule : ncrb_asserts

//--- tb/ncrb_host.sv
// switch-side master issuing configuration transactions
module ncrb_host (
	input wire logic clock,
	output ncrb_pkg::ncrb_cfg_req_t cfg_req,
	input wire ncrb_pkg::ncrb_cfg_rsp_t cfg_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cfg_req = '0;
	task automatic xfer(
		input logic wr,
		input logic [7:0] addr,
		input logic [31:0] data,
		output logic ack,
		output logic [31:0] rd
	);
		@(posedge clock);
		cfg_req <= '{1'b1, wr, addr, data};
		@(posedge clock);
		// released lines never hold a stale value
		cfg_req <= {1'b0, ~cfg_req[40:0]};
		#1;
		ack = cfg_rsp.ack;
		rd = cfg_rsp.rdata;
	endtask : xfer
endmodule : ncrb_host

//--- tb/tb.sv
// self-checking bench for the node configuration register bank
`define CHK(got, exp) \
	begin checked++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR %0t got %0h exp %0h", $time, got, exp); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] boot_select_pins;
	logic [13:0] otp_user_code;
	logic [17:0] metal_id_code;
	ncrb_pkg::ncrb_cfg_req_t cfg_req;
	ncrb_pkg::ncrb_cfg_rsp_t cfg_rsp;
	ncrb_pkg::ncrb_route_req_t route_req;
	ncrb_pkg::ncrb_route_rsp_t route_rsp;
	logic one_byte_hdr_q, pll_bypass_q, boot_from_jtag_q, pll_no_relock_q;
	logic pll_apply_q, tile_reset_q;
	logic [15:0] node_id_q, switch_div_q, ref_div_q;
	logic [2:0] pll_out_div_q;
	logic [12:0] pll_fb_mult_q;
	logic [6:0] pll_in_div_q;
	logic [31:0] shadow [0:255];
	int err_count = 0;
	int checked = 0;

	ncrb_node_config dut (.clock, .rst, .boot_select_pins, .otp_user_code,
		.metal_id_code, .cfg_req, .cfg_rsp, .route_req, .route_rsp,
		.one_byte_hdr_q, .node_id_q, .pll_out_div_q, .pll_fb_mult_q,
		.pll_in_div_q, .pll_bypass_q, .boot_from_jtag_q, .pll_no_relock_q,
		.pll_apply_q, .tile_reset_q, .switch_div_q, .ref_div_q);
	ncrb_host host (.clock, .cfg_req, .cfg_rsp);

	// clock and watchdog
	initial
	begin
		forever #4 clock = ~clock;
	end
	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		stop_test();
	end

	// expected register map
	function automatic logic mapped(input logic [7:0] a);
		return a inside {8'h00, 8'h01, [8'h04:8'h0A], 8'h0C, 8'h0D, 8'h10};
	endfunction : mapped
	function automatic logic [31:0] wmask(input logic [7:0] a);
		case (a)
			8'h04: return ncrb_pkg::GUARD_WRITE_MASK;
			8'h05, 8'h07, 8'h08: return ncrb_pkg::LOW16_MASK;
			8'h06: return ncrb_pkg::PLL_WRITE_MASK;
			8'h0C, 8'h0D: return 32'hFFFF_FFFF;
			8'h10: return ncrb_pkg::SPARE_WRITE_MASK;
			default: return 32'h0000_0000;
		endcase
	endfunction : wmask

	// bus cycles with comparison
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
		input logic exp_ack);
		logic ack;
		logic [31:0] rd;
		host.xfer(1'b1, a, d, ack, rd);
		`CHK(ack, exp_ack)
		if (exp_ack)
			shadow[a] = (shadow[a] & ~wmask(a)) | (d & wmask(a));
	endtask : wr_chk
	task automatic rd_chk(input logic [7:0] a);
		logic ack;
		logic [31:0] rd;
		host.xfer(1'b0, a, 32'h0000_0000, ack, rd);
		`CHK(ack, mapped(a))
		`CHK(rd, shadow[a])
	endtask : rd_chk
	task automatic route_chk(input logic [15:0] dest);
		logic [15:0] mm;
		logic [63:0] tbl;
		int dim;
		mm = dest ^ shadow[5][15:0];
		tbl = {shadow[8'h0D], shadow[8'h0C]};
		dim = 0;
		for (int k = 0; k < 16; k++)
			if (mm[k])
				dim = k;
		@(posedge clock);
		route_req <= '{1'b1, dest};
		@(posedge clock);
		route_req <= '{1'b0, ~dest};
		#1;
		`CHK(route_rsp.valid, 1'b1)
		`CHK(route_rsp.local_hit, mm == 16'h0000)
		`CHK(route_rsp.dim, 4'(dim))
		`CHK(route_rsp.dir, mm == 0 ? 4'h0 : tbl[dim * 4 +: 4])
	endtask : route_chk

	task automatic stop_test();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	// main sequence
	initial
	begin
		logic [7:0] a;
		void'($urandom(32'h3F3B));
		boot_select_pins = 8'($urandom);
		otp_user_code = 14'($urandom);
		metal_id_code = 18'($urandom);
		route_req = '0;
		foreach (shadow[i])
			shadow[i] = 32'h0000_0000;
		shadow[0] = {8'h00, boot_select_pins, ncrb_pkg::SWITCH_REVISION,
			ncrb_pkg::SWITCH_VERSION};
		shadow[1] = {8'h00, ncrb_pkg::SERIAL_LINK_COUNT,
			ncrb_pkg::SWITCH_PROC_COUNT, ncrb_pkg::DEVICE_PROC_COUNT};
		shadow[8] = 32'h0000_0003;
		shadow[9] = ncrb_pkg::JTAG_ID_VALUE;
		shadow[10] = {otp_user_code, metal_id_code};
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		`CHK(ref_div_q, 16'h0003)
		`CHK(one_byte_hdr_q, 1'b0)
		for (int i = 0; i < 18; i++)
			rd_chk(8'(i));
		// pll boundary words, then random traffic
		wr_chk(8'h06, 32'hFFFF_FFFF, 1'b1);
		rd_chk(8'h06);
		wr_chk(8'h06, 32'h0000_0000, 1'b1);
		for (int i = 0; i < 80; i++)
		begin
			a = 8'($urandom_range(0, 16));
			if (a == 8'h04)
				continue;
			wr_chk(a, $urandom, mapped(a) && wmask(a) != 0);
			rd_chk(a);
		end
		`CHK(node_id_q, shadow[5][15:0])
		`CHK(pll_out_div_q, shadow[6][25:23])
		`CHK(pll_in_div_q, shadow[6][6:0])
		`CHK(switch_div_q, shadow[7][15:0])
		`CHK(ref_div_q, shadow[8][15:0])
		for (int i = 0; i < 40; i++)
			route_chk(i < 35 ? 16'($urandom) :
				shadow[5][15:0] ^ (16'h0001 << ((i - 35) * 5)));
		// guard bits: header size, pll lock, full lock
		wr_chk(8'h04, 32'h0000_0001, 1'b1);
		`CHK(one_byte_hdr_q, 1'b1)
		// pll lock only, reserved guard bits ignored
		wr_chk(8'h04, 32'h7FFF_FFFE, 1'b1);
		`CHK(one_byte_hdr_q, 1'b0)
		wr_chk(8'h06, 32'h8000_0005, 1'b0);
		rd_chk(8'h06);
		rd_chk(8'h04);
		wr_chk(8'h04, 32'h8000_0101, 1'b1);
		wr_chk(8'h07, 32'h0000_1234, 1'b0);
		wr_chk(8'h04, 32'h0000_0000, 1'b0);
		rd_chk(8'h07);
		rd_chk(8'h04);
		stop_test();
	end
endmodule : tb

bind ncrb_node_config ncrb_asserts chk (.clock, .rst, .cfg_req, .cfg_rsp,
	.route_req, .route_rsp, .node_id_q, .pll_fb_mult_q, .pll_bypass_q,
	.boot_from_jtag_q, .pll_no_relock_q, .pll_apply_q, .tile_reset_q,
	.ref_div_q);
